// file: fcc_top.sv
// Contract
// RULE1: divider bit 7 read-only loaded flag; bits 6:0 writable once after reset.
// RULE2: loaded flag cleared by reset, set by first divider write, any data.
// RULE3: program and erase disabled until the loaded flag is one.
// RULE4: prescale bit one feeds divider with bus clock divided by eight.
// RULE5: divider divides its input by divisor field plus one.
// RULE6: software picks settings giving a flash clock of 150 to 200 kHz.
// RULE7: sequencer times operations in whole flash clock pulses.
// RULE8: options byte copied from nonvolatile storage during reset. The code copies it on the first clock edge after reset is released.
// RULE9: options bits 5:2 read zero; options register ignores all writes.
// RULE10: backdoor disabled means no key unlock and no debug key writes.
// RULE11: with backdoor on, matching eight bytes in order unlocks until reset.
// RULE12: redirect-disable bit one disables vector redirection, zero enables it.
// RULE13: security code 1:0 means unsecured; other three codes mean secure.
// RULE14: while secure, block memory accesses from unsecured sources.
// RULE15: security code becomes 1:0 after key unlock or all-blank check.
// RULE16: config bits 7:5 read and write freely; bits 4:0 read zero.
// RULE17: key-select one makes key writes comparisons, zero makes command starts.
// RULE18: program or erase before divider write raises access error, ignored.
// RULE19: clearing key-select after eight bytes triggers the key comparison.
// RULE20: flash clock is a one-cycle enable pulse per divided period.
`timescale 1ns/1ps
module fcc_top
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // ahb-lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  // origin of the current bus access, valid with the address phase
  input  wire logic               src_secure_mem,
  input  wire logic               src_background_debug,
  // nonvolatile contents
  input  wire logic [7:0]         options_nonvolatile_byte,
  input  wire logic [63:0]        stored_backdoor_key,
  // command start from key-location writes
  output logic                    cmd_start,
  output logic [2:0]              cmd_start_idx,
  output logic [7:0]              cmd_start_data,
  // program and erase sequencer
  input  wire logic               pe_request,
  input  wire logic [PULSE_W-1:0] pe_pulses,
  output logic                    pe_busy,
  output logic                    pe_done,
  output logic                    pe_enabled,
  input  wire logic               blank_check_erased,
  // memory guard
  input  wire logic               mem_access_unsecured_src,
  output logic                    mem_access_block,
  // status
  output logic                    flash_timing_clock,
  output logic                    access_error_flag,
  output logic                    device_secure,
  output logic                    redirect_enable
);

  // ==========================================================================
  // state
  // ==========================================================================
  fcc_aphase_t          aph_r;
  fcc_aphase_t          aph_nxt;
  logic [7:0]           div_r;
  logic [7:0]           div_nxt;
  logic [1:0]           opt_hi_r;
  logic [1:0]           opt_hi_nxt;
  logic [SEC_W-1:0]     sec_r;
  logic [SEC_W-1:0]     sec_nxt;
  logic                 opt_pend_r;
  logic [7:0]           cfg_r;
  logic [7:0]           cfg_nxt;
  logic                 accerr_r;
  logic                 accerr_nxt;
  logic                 busy_r;
  logic                 busy_nxt;
  logic [PULSE_W-1:0]   pcnt_r;
  logic [PULSE_W-1:0]   pcnt_nxt;
  logic                 done_r;
  logic                 cmd_r;
  logic [2:0]           cmd_idx_r;
  logic [7:0]           cmd_data_r;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;

  wire                  ap_take;
  wire                  wr_en;
  wire [7:0]            wdat;
  wire                  wr_div;
  wire                  wr_cfg;
  wire                  wr_stat;
  wire                  wr_key;
  wire                  loaded;
  wire                  keysel;
  wire                  key_enable;
  wire                  key_open;
  wire                  key_close;
  wire                  cmd_go;
  wire                  cmd_reject;
  wire                  pe_accept;
  wire                  pe_reject;
  wire                  pe_last;
  wire                  unlock;
  wire                  flash_tick;
  wire                  accerr_set;
  wire [7:0]            opt_view;
  wire [7:0]            stat_view;
  wire [7:0]            rd_byte;
  fcc_keywr_t           key_wr;

  // ==========================================================================
  // bus address and data phase
  // ==========================================================================
  assign ap_take            = hsel & htrans[1] & hready;
  assign aph_nxt.valid      = ap_take;
  assign aph_nxt.write      = hwrite;
  assign aph_nxt.in_range   = haddr[31:8] == 24'h000000;
  assign aph_nxt.src_secure = src_secure_mem;
  assign aph_nxt.src_debug  = src_background_debug;
  assign aph_nxt.addr       = haddr[7:0];

  assign wr_en   = aph_r.valid & aph_r.write & aph_r.in_range;
  assign wdat    = hwdata[7:0];
  assign wr_div  = wr_en & (aph_r.addr == OFF_DIV);
  assign wr_cfg  = wr_en & (aph_r.addr == OFF_CFG);
  assign wr_stat = wr_en & (aph_r.addr == OFF_STAT);
  assign wr_key  = wr_en & fcc_key_hit(aph_r.addr) & (aph_r.addr[1:0] == 2'h0);

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // ==========================================================================
  // divider register
  // ==========================================================================
  assign loaded = div_r[DIV_LOADED_BIT];
  // RULE1: write once, bit 7 not writable
  // RULE2: first write sets the flag
  assign div_nxt = (wr_div & ~loaded) ? ((wdat & DIV_WR_MASK) | (8'h01 << DIV_LOADED_BIT)) : div_r;
  // RULE3: gate program and erase
  assign pe_enabled = loaded;

  fcc_clkgen u_clkgen (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .run               (loaded),
    .prescale_by_eight (div_r[DIV_PRESCALE_BIT]),
    .divisor_field     (div_r[DIV_FIELD_W-1:0]),
    .flash_tick        (flash_tick)
  );
  assign flash_timing_clock = flash_tick;

  // ==========================================================================
  // options and security
  // ==========================================================================
  // RULE8: copy the stored byte on the first edge after reset
  assign opt_hi_nxt = opt_pend_r ? options_nonvolatile_byte[OPT_BACKDOOR_BIT -: 2] : opt_hi_r;
  // RULE15: unlock or blank flash clears security
  assign sec_nxt    = opt_pend_r                   ? options_nonvolatile_byte[SEC_W-1:0] :
                      (unlock | blank_check_erased) ? SEC_UNSECURED : sec_r;
  // RULE9: unused bits zero, no write path
  assign opt_view   = {opt_hi_r, 4'h0, sec_r};
  // RULE13: only 1:0 is unsecured
  assign device_secure   = fcc_is_secure(sec_r);
  // RULE12: redirect-disable bit
  assign redirect_enable = ~opt_hi_r[OPT_REDIR_BIT-6];
  // RULE14: guard secure memory
  assign mem_access_block = fcc_is_secure(sec_r) & mem_access_unsecured_src;

  // ==========================================================================
  // configuration and backdoor key
  // ==========================================================================
  // RULE16: only bits 7:5 are kept
  assign cfg_nxt   = wr_cfg ? (wdat & CFG_RW_MASK) : cfg_r;
  assign keysel    = cfg_r[CFG_KEYSEL_BIT];
  assign key_open  = wr_cfg & ~keysel & wdat[CFG_KEYSEL_BIT];
  // RULE19: falling key-select closes the session
  assign key_close = wr_cfg & keysel & ~wdat[CFG_KEYSEL_BIT];
  // RULE10: backdoor only for secure code, never debug
  assign key_enable = opt_hi_r[OPT_BACKDOOR_BIT-6] & aph_r.src_secure & ~aph_r.src_debug;

  // RULE17: key-select steers key location writes
  assign key_wr.valid = wr_key & keysel;
  assign key_wr.idx   = aph_r.addr[4:2];
  assign key_wr.data  = wdat;
  assign cmd_go       = wr_key & ~keysel & loaded;
  // RULE18: command start before divider write is refused
  assign cmd_reject   = wr_key & ~keysel & ~loaded;

  fcc_keycmp u_keycmp (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .open                (key_open),
    .close               (key_close),
    .enable              (key_enable),
    .key_wr              (key_wr),
    .stored_backdoor_key (stored_backdoor_key),
    .unlock              (unlock)
  );

  assign cmd_start      = cmd_r;
  assign cmd_start_idx  = cmd_idx_r;
  assign cmd_start_data = cmd_data_r;

  // ==========================================================================
  // program and erase sequencer
  // ==========================================================================
  assign pe_accept = pe_request & loaded & ~busy_r;
  // RULE18: refused before divider write
  assign pe_reject = pe_request & ~loaded;
  // RULE7: count whole flash clock pulses
  assign pe_last   = busy_r & flash_tick & (pcnt_r <= PULSE_ONE);
  assign busy_nxt  = pe_accept | (busy_r & ~pe_last);
  assign pcnt_nxt  = pe_accept                ? ((pe_pulses == '0) ? PULSE_ONE : pe_pulses) :
                     (busy_r & flash_tick)    ? PULSE_W'(pcnt_r - PULSE_ONE) : pcnt_r;
  assign pe_busy   = busy_r;
  assign pe_done   = done_r;

  // ==========================================================================
  // status register
  // ==========================================================================
  assign accerr_set = pe_reject | cmd_reject;
  // new error wins over a write-one clear in the same cycle
  assign accerr_nxt = accerr_set | (accerr_r & ~(wr_stat & wdat[STAT_ACCERR_BIT]));
  assign access_error_flag = accerr_r;
  assign stat_view = (8'(accerr_r) << STAT_ACCERR_BIT)
                   | (8'(device_secure) << STAT_SECURE_BIT)
                   | (8'(busy_r) << STAT_BUSY_BIT);

  // ==========================================================================
  // read mux
  // ==========================================================================
  // next-state divider and config values so a read right after a write sees the new contents
  assign rd_byte = ~aph_nxt.in_range      ? 8'h00 :
                   (haddr[7:0] == OFF_DIV)  ? div_nxt :
                   (haddr[7:0] == OFF_OPT)  ? opt_view :
                   (haddr[7:0] == OFF_CFG)  ? cfg_nxt :
                   (haddr[7:0] == OFF_STAT) ? stat_view : 8'h00;
  assign rdata_nxt = (ap_take & ~hwrite) ? {24'h000000, rd_byte} : 32'h00000000;

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r      <= '0;
      div_r      <= DIV_RESET;
      opt_hi_r   <= OPT_HI_RESET;
      sec_r      <= SEC_RESET;
      opt_pend_r <= 1'b1;
      cfg_r      <= CFG_RESET;
      accerr_r   <= 1'b0;
      busy_r     <= 1'b0;
      pcnt_r     <= '0;
      done_r     <= 1'b0;
      cmd_r      <= 1'b0;
      cmd_idx_r  <= 3'h0;
      cmd_data_r <= 8'h00;
      rdata_r    <= 32'h00000000;
    end else begin
      aph_r      <= aph_nxt;
      div_r      <= div_nxt;
      opt_hi_r   <= opt_hi_nxt;
      sec_r      <= sec_nxt;
      opt_pend_r <= 1'b0;
      cfg_r      <= cfg_nxt;
      accerr_r   <= accerr_nxt;
      busy_r     <= busy_nxt;
      pcnt_r     <= pcnt_nxt;
      done_r     <= pe_last;
      cmd_r      <= cmd_go;
      cmd_idx_r  <= cmd_go ? key_wr.idx : cmd_idx_r;
      cmd_data_r <= cmd_go ? wdat : cmd_data_r;
      rdata_r    <= rdata_nxt;
    end
  end

endmodule // fcc_top

// file: fcc_pkg.sv
package fcc_pkg;

  // ==========================================================================
  // register map (byte addresses on the bus)
  // ==========================================================================
  localparam logic [7:0] OFF_DIV  = 8'h00;
  localparam logic [7:0] OFF_OPT  = 8'h04;
  localparam logic [7:0] OFF_CFG  = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  // eight key locations, one word each, 0x20..0x3c
  localparam logic [2:0] KEY_PAGE = 3'h1;
  localparam int unsigned KEY_BYTES = 8;

  // ==========================================================================
  // field layout and reset values
  // ==========================================================================
  localparam int unsigned DIV_LOADED_BIT   = 7;
  localparam int unsigned DIV_PRESCALE_BIT = 6;
  localparam int unsigned DIV_FIELD_W      = 6;
  localparam logic [7:0]  DIV_RESET        = 8'h00;
  localparam logic [7:0]  DIV_WR_MASK      = 8'h7f;

  localparam int unsigned OPT_BACKDOOR_BIT = 7;
  localparam int unsigned OPT_REDIR_BIT    = 6;
  localparam logic [1:0]  OPT_HI_RESET     = 2'h0;
  localparam int unsigned SEC_W            = 2;
  localparam logic [1:0]  SEC_UNSECURED    = 2'h2;
  localparam logic [1:0]  SEC_RESET        = 2'h3;

  localparam int unsigned CFG_KEYSEL_BIT   = 5;
  localparam logic [7:0]  CFG_RW_MASK      = 8'he0;
  localparam logic [7:0]  CFG_RESET        = 8'h00;

  localparam int unsigned STAT_ACCERR_BIT  = 0;
  localparam int unsigned STAT_SECURE_BIT  = 1;
  localparam int unsigned STAT_BUSY_BIT    = 2;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam logic [2:0]  PRE_CNT_MAX      = 3'h7;   // divide by 8
  localparam int unsigned PULSE_W          = 16;
  localparam logic [15:0] PULSE_ONE        = 16'h0001;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       in_range;
    logic       src_secure;
    logic       src_debug;
    logic [7:0] addr;
  } fcc_aphase_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] idx;
    logic [7:0] data;
  } fcc_keywr_t;

  function automatic logic fcc_is_secure(input logic [1:0] code);
    return code != SEC_UNSECURED;
  endfunction

  function automatic logic fcc_key_hit(input logic [7:0] addr);
    return addr[7:5] == KEY_PAGE;
  endfunction

endpackage

// file: fcc_clkgen.sv
`timescale 1ns/1ps
module fcc_clkgen
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // divider setting
  input  wire logic                   run,
  input  wire logic                   prescale_by_eight,
  input  wire logic [DIV_FIELD_W-1:0] divisor_field,
  // flash timing tick
  output logic                        flash_tick
);

  logic [2:0]             pre_cnt_r;
  logic [2:0]             pre_cnt_nxt;
  logic [DIV_FIELD_W-1:0] div_cnt_r;
  logic [DIV_FIELD_W-1:0] div_cnt_nxt;
  logic                   tick_r;
  logic                   tick_nxt;
  wire                    pre_tick;
  wire                    div_wrap;

  // ==========================================================================
  // prescaler and divider
  // ==========================================================================
  // RULE4: optional divide by eight
  assign pre_tick    = run & (~prescale_by_eight | (pre_cnt_r == PRE_CNT_MAX));
  assign pre_cnt_nxt = (run & prescale_by_eight) ? 3'(pre_cnt_r + 3'h1) : 3'h0;
  // RULE5: divide by field plus one
  assign div_wrap    = pre_tick & (div_cnt_r == divisor_field);
  assign div_cnt_nxt = ~run     ? '0 :
                       div_wrap ? '0 :
                       pre_tick ? DIV_FIELD_W'(div_cnt_r + 1'b1) : div_cnt_r;
  // RULE20: one-cycle enable, not a clock
  assign tick_nxt    = div_wrap;
  assign flash_tick  = tick_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= '0;
      tick_r    <= 1'b0;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
      tick_r    <= tick_nxt;
    end
  end

endmodule // fcc_clkgen

// file: fcc_keycmp.sv
`timescale 1ns/1ps
module fcc_keycmp
  import fcc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // session control
  input  wire logic        open,
  input  wire logic        close,
  input  wire logic        enable,
  input  wire fcc_keywr_t  key_wr,
  input  wire logic [63:0] stored_backdoor_key,
  // result
  output logic             unlock
);

  logic [3:0] next_idx_r;
  logic [3:0] next_idx_nxt;
  logic       ok_r;
  logic       ok_nxt;
  logic       unlock_r;
  wire  [7:0] expect_byte;
  wire        good;
  wire        all_in;

  // ==========================================================================
  // ordered comparison
  // ==========================================================================
  assign expect_byte = stored_backdoor_key[8*key_wr.idx +: 8];
  assign all_in      = next_idx_r == 4'(KEY_BYTES);
  // RULE11: ascending order, byte for byte
  assign good        = ~all_in & (key_wr.idx == next_idx_r[2:0]) & (key_wr.data == expect_byte);
  assign next_idx_nxt = open                           ? 4'h0 :
                        (key_wr.valid & enable & good) ? 4'(next_idx_r + 4'h1) : next_idx_r;
  assign ok_nxt      = open ? 1'b1 : (ok_r & ~(key_wr.valid & enable & ~good));
  assign unlock      = unlock_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_idx_r <= 4'h0;
      ok_r       <= 1'b0;
      unlock_r   <= 1'b0;
    end else begin
      next_idx_r <= next_idx_nxt;
      ok_r       <= ok_nxt;
      // RULE19: judge on session close
      unlock_r   <= close & enable & ok_r & all_in;
    end
  end

endmodule // fcc_keycmp

// file: fcc_top_checker.sv
`timescale 1ns/1ps
module fcc_top_checker
  import fcc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sequencer and commands
  input wire logic pe_request,
  input wire logic pe_busy,
  input wire logic pe_done,
  input wire logic pe_enabled,
  input wire logic cmd_start,
  // guard and status
  input wire logic mem_access_unsecured_src,
  input wire logic mem_access_block,
  input wire logic device_secure,
  input wire logic flash_timing_clock,
  input wire logic access_error_flag
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ==========================================================================
  // loaded flag and gating
  // ==========================================================================
  a_flag_stays: assert property (pe_enabled |=> pe_enabled)
    else $error("loaded flag dropped without reset");
  a_start_needs_load: assert property (cmd_start |-> pe_enabled)
    else $error("command start while divider not loaded");
  a_busy_needs_load: assert property ($rose(pe_busy) |-> $past(pe_request) && pe_enabled)
    else $error("sequencer started without loaded request");
  a_error_unloaded: assert property (pe_request && !pe_enabled |=> access_error_flag [*2])
    else $error("unloaded request did not flag an error");

  // ==========================================================================
  // timing pulses and memory guard
  // ==========================================================================
  a_tick_needs_load: assert property (flash_timing_clock |-> pe_enabled)
    else $error("timing tick before divider loaded");
  a_done_ends_busy: assert property (pe_done |-> !pe_busy && $past(pe_busy))
    else $error("done pulse not at end of busy");
  a_end_on_tick: assert property ($fell(pe_busy) |-> $past(flash_timing_clock))
    else $error("operation ended off a timing tick");
  a_block_guard: assert property (mem_access_block == (device_secure && mem_access_unsecured_src))
    else $error("memory block does not follow security");
endmodule // fcc_top_checker

bind fcc_top fcc_top_checker fcc_top_checker_i (
  .hclk(hclk), .hresetn(hresetn), .pe_request(pe_request), .pe_busy(pe_busy), .pe_done(pe_done),
  .pe_enabled(pe_enabled), .cmd_start(cmd_start), .mem_access_unsecured_src(mem_access_unsecured_src),
  .mem_access_block(mem_access_block), .device_secure(device_secure),
  .flash_timing_clock(flash_timing_clock), .access_error_flag(access_error_flag)
);

// file: fcc_ahb_master.sv
`timescale 1ns/1ps
module fcc_ahb_master (
  // clock and answer
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

  // single word transfer; address phase held until hready, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    {hsel, htrans, hwrite, hsize, haddr} <= {1'b1, 2'h2, w, 3'h2, 24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    {htrans, hwdata} <= {2'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // released data must not look like a held value
    {hsel, hwdata} <= {1'b0, ~wd};
  endtask
endmodule // fcc_ahb_master

// file: fcc_top_tb_top.sv
`timescale 1ns/1ps
module fcc_top_tb_top;
  import fcc_pkg::*;
  localparam logic [63:0] KEY  = 64'h8877665544332211;
  localparam logic [7:0]  NV_A = 8'hbf;
  localparam logic [7:0]  NV_B = 8'h43;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        src_secure_mem = 1'b1;
  logic        src_background_debug = 1'b0;
  logic        mem_access_unsecured_src = 1'b1;
  logic [7:0]  options_nonvolatile_byte = 8'h00;
  logic [63:0] stored_backdoor_key = KEY;
  logic        pe_request = 1'b0;
  logic        blank_check_erased = 1'b0;
  logic [15:0] pe_pulses = 16'h0001;
  logic        cmd_start, pe_busy, pe_done, pe_enabled, mem_access_block;
  logic        flash_timing_clock, access_error_flag, device_secure, redirect_enable;
  logic [2:0]  cmd_start_idx;
  logic [7:0]  cmd_start_data;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          n_start = 0;

  always #2.5 hclk = ~hclk;
  always @(negedge hclk) if (cmd_start === 1'b1) n_start++;

  fcc_top fcc_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .src_secure_mem(src_secure_mem), .src_background_debug(src_background_debug),
    .options_nonvolatile_byte(options_nonvolatile_byte), .stored_backdoor_key(stored_backdoor_key),
    .cmd_start(cmd_start), .cmd_start_idx(cmd_start_idx), .cmd_start_data(cmd_start_data),
    .pe_request(pe_request), .pe_pulses(pe_pulses), .pe_busy(pe_busy), .pe_done(pe_done),
    .pe_enabled(pe_enabled), .blank_check_erased(blank_check_erased),
    .mem_access_unsecured_src(mem_access_unsecured_src), .mem_access_block(mem_access_block),
    .flash_timing_clock(flash_timing_clock), .access_error_flag(access_error_flag),
    .device_secure(device_secure), .redirect_enable(redirect_enable)
  );
  fcc_ahb_master fcc_ahb_master_i (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    fcc_ahb_master_i.xfer(1'b1, a, d, rd_q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    fcc_ahb_master_i.xfer(1'b0, a, 32'h0, rd_q);
    chk(what, exp, rd_q);
    chk("resp", 0, hresp);
  endtask
  task automatic do_reset(input logic [7:0] nv);
    @(posedge hclk);
    hresetn <= 1'b0;
    options_nonvolatile_byte <= nv;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  task automatic next_tick(output int n);
    n = 0;
    do begin @(negedge hclk); n++; end while (flash_timing_clock !== 1'b1 && n < 200);
  endtask
  task automatic test_done();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_state(input logic [7:0] nv);
    rd(OFF_DIV, 32'h0, "divider");
    rd(OFF_OPT, {24'h0, nv[7:6], 4'h0, nv[1:0]}, "options");
    chk("secure", nv[1:0] != 2'b10, device_secure);
    chk("redirect", !nv[6], redirect_enable);
  endtask
  task automatic t_unloaded();
    @(posedge hclk);
    pe_request <= 1'b1;
    @(posedge hclk);
    pe_request <= 1'b0;
    n_start = 0;
    wr(8'h20, 32'h11);
    repeat (2) @(negedge hclk);
    chk("error", 1'b1, access_error_flag);
    chk("busy", 1'b0, pe_busy);
    chk("starts", 0, n_start);
    wr(OFF_STAT, 32'h1);
    rd(OFF_STAT, 32'h2, "status");
  endtask
  task automatic t_div_once();
    wr(OFF_DIV, 32'h42); // fast for sim
    rd(OFF_DIV, 32'hc2, "divider");
    wr(OFF_DIV, 32'h05);
    rd(OFF_DIV, 32'hc2, "divider");
    wr(OFF_OPT, 32'h0);
    rd(OFF_OPT, 32'h83, "options");
    chk("enabled", 1'b1, pe_enabled);
  endtask
  task automatic t_tick();
    int n;
    next_tick(n);
    next_tick(n);
    chk("tick period", 8 * 3, n);
  endtask
  task automatic t_seq();
    int t, d;
    {t, d} = '0;
    @(posedge hclk);
    pe_pulses <= 16'h0003;
    pe_request <= 1'b1;
    @(posedge hclk);
    pe_request <= 1'b0;
    repeat (120) begin
      @(negedge hclk);
      t += int'(pe_busy === 1'b1 && flash_timing_clock === 1'b1);
      d += int'(pe_done === 1'b1);
    end
    chk("ticks in op", 3, t);
    chk("done pulses", 1, d);
  endtask
  task automatic t_cfg();
    wr(OFF_CFG, 32'hff);
    rd(OFF_CFG, 32'he0, "config");
    wr(8'h14, 32'hff);
    rd(8'h14, 32'h0, "unmapped");
    wr(OFF_CFG, 32'h0);
  endtask
  task automatic t_cmd();
    n_start = 0;
    wr(8'h24, 32'h5a);
    repeat (2) @(negedge hclk);
    chk("starts", 1, n_start);
    chk("start data", {3'h1, 8'h5a}, {cmd_start_idx, cmd_start_data});
  endtask
  task automatic t_key(input logic [63:0] k, input logic exp_sec);
    n_start = 0;
    wr(OFF_CFG, 32'h20);
    for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), {24'h0, k[8 * i +: 8]});
    wr(OFF_CFG, 32'h0);
    repeat (3) @(negedge hclk);
    chk("secure", exp_sec, device_secure);
    chk("block", exp_sec, mem_access_block);
    chk("starts", 0, n_start);
  endtask
  task automatic t_blank();
    @(posedge hclk);
    blank_check_erased <= 1'b1;
    @(posedge hclk);
    blank_check_erased <= 1'b0;
    repeat (3) @(negedge hclk);
    chk("secure", 1'b0, device_secure);
  endtask

  initial begin
    do_reset(NV_A);
    t_state(NV_A);
    t_unloaded();
    t_div_once();
    t_tick();
    t_seq();
    t_cfg();
    t_cmd();
    t_key(KEY ^ 64'h0100000000000000, 1'b1);
    @(posedge hclk) src_background_debug <= 1'b1;
    t_key(KEY, 1'b1);
    @(posedge hclk) src_background_debug <= 1'b0;
    t_key(KEY, 1'b0);
    do_reset(NV_B);
    t_state(NV_B);
    t_key(KEY, 1'b1);
    t_blank();
    test_done();
  end

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #100000;
    num_errors++;
    test_done();
  end
endmodule // fcc_top_tb_top
